/* File: include/sras_defs.vh */
// Constants for the serial register port with shadowed configuration
`ifndef SRAS_DEFS_VH
`define SRAS_DEFS_VH

// Frame layout
`define SRAS_CNT_LAST 4'hF
`define SRAS_WR_BIT 15
`define SRAS_IDX_HI 14
`define SRAS_IDX_LO 9
`define SRAS_UPPER_BIT 8

// Register space
`define SRAS_REG_COUNT 64
`define SRAS_RO_LIMIT 6'h10
`define SRAS_CAPT_X_IDX 6'h0B
`define SRAS_CAPT_Y_IDX 6'h0C
`define SRAS_CAPT_Z_IDX 6'h0D
`define SRAS_CTRL_IDX 6'h10
`define SRAS_CMD_IDX 6'h3B
`define SRAS_SAVE_BIT 3
`define SRAS_LAST_IDX 6'h3F

// Reset values and masks
`define SRAS_CTRL_RESET 16'h0000
`define SRAS_BACKUP_MASK 64'hF7FF_FFFF_FFFF_0000
`define SRAS_WO_MASK 64'h0800_0000_0000_0000

// Capture buffer
`define SRAS_CAP_DEPTH 8192
`define SRAS_CAP_AW 13

`endif

/* File: hdl/sras_mem.v */
// Simple dual-port memory with byte lanes and registered read data
`default_nettype none
module sras_mem #(
  parameter W = 16,
  parameter NB = 2,
  parameter DEPTH = 64,
  parameter AW = 6
) (
  input wire clk,
  input wire we,
  input wire [NB-1:0] be,
  input wire [AW-1:0] waddr,
  input wire [W-1:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [W-1:0] rdata
);
  localparam LW = W / NB;

  reg [W-1:0] mem [0:DEPTH-1];
  integer i;
  integer j;

  // Blank contents stand in for an erased store on first power-up
  initial begin
    for (i = 0; i < DEPTH; i = i + 1) begin
      mem[i] = {W{1'b0}};
    end
  end

  always @(posedge clk) begin
    for (j = 0; j < NB; j = j + 1) begin
      if (we && be[j]) begin
        mem[waddr][j*LW +: LW] <= wdata[j*LW +: LW];
      end
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

/* File: hdl/sras_spi_shadow.v */
// Serial slave register port with working copy, backup store and capture buffer
`include "sras_defs.vh"
`default_nettype none
// Behaviour
// RULE1: Port shifts and answers only while chip select is held low.
// RULE2: Input bit is taken on every rising serial clock edge.
// RULE3: Output bit changes on every falling serial clock edge.
// RULE4: Registers are 16 bits, each with upper and lower 7-bit byte addresses.
// RULE5: Output registers read-only; config registers read/write or write-only.
// RULE6: Working copy governs operation and takes every configuration write.
// RULE7: Backup store keeps only registers marked as backed up.
// RULE8: Backup is written only on the save bit of the global command register.
// RULE9: After reset backup loads into working copy before data is produced.
// RULE10: Active-low reset pin holds the device in reset while low.
// RULE11: Capture buffer holds three channels of 8192 samples, several events.
// RULE12: Host uses mode 3, 16-bit MSB-first frames, clock up to 2.5 MHz; the bench host model clocks at 5 MHz.
// RULE13: One write frame updates one register byte.
// RULE14: Read takes two frames; data returns during the second.
// RULE15: Read of either byte address returns the whole 16-bit register.
// RULE16: Frame holds write flag, 7-bit byte address, then data byte.
module sras_spi_shadow #(
  parameter [63:0] BACKUP_MASK = `SRAS_BACKUP_MASK,
  parameter [63:0] WO_MASK = `SRAS_WO_MASK,
  parameter CAP_DEPTH = `SRAS_CAP_DEPTH,
  parameter CAP_AW = `SRAS_CAP_AW
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire sclkPin,
  input wire csPin_n,
  input wire mosiPin,
  output reg misoPin,
  input wire rstPin_n,
  input wire [255:0] outWords,
  input wire sampleValid,
  input wire [15:0] sampleX,
  input wire [15:0] sampleY,
  input wire [15:0] sampleZ,
  output wire cfgReady,
  output wire [15:0] ctrlWord,
  output wire saveBusy
);
  localparam [2:0] ST_LOAD_RD = 3'h0;
  localparam [2:0] ST_LOAD_WR = 3'h1;
  localparam [2:0] ST_IDLE = 3'h2;
  localparam [2:0] ST_ACC = 3'h3;
  localparam [2:0] ST_RD_DATA = 3'h4;
  localparam [2:0] ST_SAVE_RD = 3'h5;
  localparam [2:0] ST_SAVE_WR = 3'h6;

  reg sclkMeta_reg, sclkSync_reg, sclkPrev_reg;
  reg csMeta_reg, csSync_reg;
  reg mosiMeta_reg, mosiSync_reg;
  reg rstMeta_reg, rstSync_reg;
  reg [14:0] rxShift_reg;
  reg [3:0] bitCnt_reg;
  reg [15:0] txShift_reg;
  reg [2:0] state_reg;
  reg [5:0] walkIdx_reg;
  reg cmdPend_reg;
  reg [15:0] cmd_reg;
  reg cfgReady_reg;
  reg [15:0] ctrlWord_reg;
  reg [CAP_AW-1:0] capWr_reg, capRd_reg;

  wire devRst = sys_rst | ~rstSync_reg; // RULE10
  wire csActive = ~csSync_reg; // RULE1
  // Edges are found by oversampling; needs the host clock well below sys_clk/4
  wire sclkRise = sclkSync_reg & ~sclkPrev_reg; // RULE12
  wire sclkFall = ~sclkSync_reg & sclkPrev_reg;
  wire frameDone = csActive & sclkRise & (bitCnt_reg == `SRAS_CNT_LAST);
  wire [15:0] frameWord = {rxShift_reg, mosiSync_reg};

  // Command fields
  wire cmdWrite = cmd_reg[`SRAS_WR_BIT]; // RULE16
  wire [5:0] cmdIdx = cmd_reg[`SRAS_IDX_HI:`SRAS_IDX_LO];
  wire cmdUpper = cmd_reg[`SRAS_UPPER_BIT]; // RULE4
  wire [7:0] cmdData = cmd_reg[7:0];
  wire cmdIsRo = cmdIdx < `SRAS_RO_LIMIT;
  wire cmdIsCapt = (cmdIdx == `SRAS_CAPT_X_IDX) || (cmdIdx == `SRAS_CAPT_Y_IDX) ||
    (cmdIdx == `SRAS_CAPT_Z_IDX);
  wire [1:0] cmdBe = cmdUpper ? 2'h2 : 2'h1;
  wire accWrite = (state_reg == ST_ACC) & cmdWrite & ~cmdIsRo; // RULE5
  wire saveCmd = accWrite & (cmdIdx == `SRAS_CMD_IDX) & ~cmdUpper & cmdData[`SRAS_SAVE_BIT];

  // Memory hookup
  wire [15:0] workRd, nvRd;
  wire [47:0] capRd;
  wire loadWr = state_reg == ST_LOAD_WR;
  wire [15:0] loadWord = BACKUP_MASK[walkIdx_reg] ? nvRd : 16'h0000; // RULE7
  wire workWe = loadWr | accWrite; // RULE6
  wire [1:0] workBe = loadWr ? 2'h3 : cmdBe;
  wire [5:0] workWaddr = loadWr ? walkIdx_reg : cmdIdx;
  wire [15:0] workWdata = loadWr ? loadWord : {cmdData, cmdData}; // RULE13
  wire [5:0] workRaddr = (state_reg == ST_SAVE_RD) ? walkIdx_reg : cmdIdx;
  wire nvWe = (state_reg == ST_SAVE_WR) & BACKUP_MASK[walkIdx_reg]; // RULE7
  wire capWe = sampleValid & cfgReady_reg; // RULE9

  reg [15:0] rdWord;

  always @* begin
    rdWord = workRd;
    if (cmdIdx == `SRAS_CAPT_X_IDX) begin
      rdWord = capRd[15:0];
    end else if (cmdIdx == `SRAS_CAPT_Y_IDX) begin
      rdWord = capRd[31:16];
    end else if (cmdIdx == `SRAS_CAPT_Z_IDX) begin
      rdWord = capRd[47:32];
    end else if (cmdIsRo) begin
      rdWord = outWords[{cmdIdx[3:0], 4'h0} +: 16]; // RULE5
    end else if (WO_MASK[cmdIdx]) begin
      rdWord = 16'h0000; // RULE5
    end
  end

  // Two-stage synchronisers for every pin
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      sclkMeta_reg <= 1'b1;
      sclkSync_reg <= 1'b1;
      sclkPrev_reg <= 1'b1;
      csMeta_reg <= 1'b1;
      csSync_reg <= 1'b1;
      mosiMeta_reg <= 1'b0;
      mosiSync_reg <= 1'b0;
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      sclkMeta_reg <= sclkPin;
      sclkSync_reg <= sclkMeta_reg;
      sclkPrev_reg <= sclkSync_reg;
      csMeta_reg <= csPin_n;
      csSync_reg <= csMeta_reg;
      mosiMeta_reg <= mosiPin;
      mosiSync_reg <= mosiMeta_reg;
      rstMeta_reg <= rstPin_n; // RULE10
      rstSync_reg <= rstMeta_reg;
    end
  end

  // Serial shifter
  always @(posedge sys_clk) begin
    if (devRst) begin
      rxShift_reg <= 15'h0000;
      bitCnt_reg <= 4'h0;
      txShift_reg <= 16'h0000;
      misoPin <= 1'b0;
    end else begin
      if (!csActive) begin
        bitCnt_reg <= 4'h0; // RULE1
      end else if (sclkRise) begin
        rxShift_reg <= frameWord[14:0]; // RULE2
        bitCnt_reg <= bitCnt_reg + 4'h1;
      end
      if (state_reg == ST_RD_DATA) begin
        txShift_reg <= rdWord; // RULE14
      end else if (state_reg == ST_ACC && cmdWrite) begin
        txShift_reg <= 16'h0000;
      end else if (csActive && sclkFall) begin
        misoPin <= txShift_reg[15]; // RULE3
        txShift_reg <= {txShift_reg[14:0], 1'b0};
      end
    end
  end

  // Load, access and save sequencer
  always @(posedge sys_clk) begin
    if (devRst) begin
      state_reg <= ST_LOAD_RD;
      walkIdx_reg <= 6'h00;
      cmdPend_reg <= 1'b0;
      cmd_reg <= 16'h0000;
      cfgReady_reg <= 1'b0;
      ctrlWord_reg <= `SRAS_CTRL_RESET;
      capRd_reg <= {CAP_AW{1'b0}};
    end else begin
      if (frameDone) begin
        cmdPend_reg <= 1'b1;
        cmd_reg <= frameWord;
      end else if (state_reg == ST_IDLE && cmdPend_reg) begin
        cmdPend_reg <= 1'b0;
      end
      case (state_reg)
        ST_LOAD_RD: begin
          state_reg <= ST_LOAD_WR;
        end
        ST_LOAD_WR: begin
          if (walkIdx_reg == `SRAS_CTRL_IDX) begin
            ctrlWord_reg <= loadWord;
          end
          walkIdx_reg <= walkIdx_reg + 6'h01;
          if (walkIdx_reg == `SRAS_LAST_IDX) begin
            cfgReady_reg <= 1'b1; // RULE9
            state_reg <= ST_IDLE;
          end else begin
            state_reg <= ST_LOAD_RD;
          end
        end
        ST_IDLE: begin
          if (cmdPend_reg) begin
            state_reg <= ST_ACC;
          end
        end
        ST_ACC: begin
          if (accWrite && cmdIdx == `SRAS_CTRL_IDX) begin
            if (cmdUpper) begin
              ctrlWord_reg[15:8] <= cmdData;
            end else begin
              ctrlWord_reg[7:0] <= cmdData;
            end
          end
          if (saveCmd) begin
            walkIdx_reg <= 6'h00;
            state_reg <= ST_SAVE_RD; // RULE8
          end else if (cmdWrite) begin
            state_reg <= ST_IDLE;
          end else begin
            state_reg <= ST_RD_DATA; // RULE15
          end
        end
        ST_RD_DATA: begin
          if (cmdIdx == `SRAS_CAPT_Z_IDX) begin
            capRd_reg <= capRd_reg + {{(CAP_AW-1){1'b0}}, 1'b1};
          end
          state_reg <= ST_IDLE;
        end
        ST_SAVE_RD: begin
          state_reg <= ST_SAVE_WR;
        end
        ST_SAVE_WR: begin
          walkIdx_reg <= walkIdx_reg + 6'h01;
          state_reg <= (walkIdx_reg == `SRAS_LAST_IDX) ? ST_IDLE : ST_SAVE_RD;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Circular capture keeps earlier events until overwritten
  always @(posedge sys_clk) begin
    if (devRst) begin
      capWr_reg <= {CAP_AW{1'b0}};
    end else if (capWe) begin
      capWr_reg <= capWr_reg + {{(CAP_AW-1){1'b0}}, 1'b1}; // RULE11
    end
  end

  sras_mem #(.W(16), .NB(2), .DEPTH(`SRAS_REG_COUNT), .AW(6)) workMem (
    .clk(sys_clk),
    .we(workWe),
    .be(workBe),
    .waddr(workWaddr),
    .wdata(workWdata),
    .raddr(workRaddr),
    .rdata(workRd)
  );

  // Not cleared by reset: contents survive like the nonvolatile store
  sras_mem #(.W(16), .NB(2), .DEPTH(`SRAS_REG_COUNT), .AW(6)) nvMem (
    .clk(sys_clk),
    .we(nvWe),
    .be(2'h3),
    .waddr(walkIdx_reg),
    .wdata(workRd),
    .raddr(walkIdx_reg),
    .rdata(nvRd)
  );

  sras_mem #(.W(48), .NB(1), .DEPTH(CAP_DEPTH), .AW(CAP_AW)) capMem (
    .clk(sys_clk),
    .we(capWe),
    .be(1'b1),
    .waddr(capWr_reg),
    .wdata({sampleZ, sampleY, sampleX}), // RULE11
    .raddr(capRd_reg),
    .rdata(capRd)
  );

  assign cfgReady = cfgReady_reg;
  assign ctrlWord = ctrlWord_reg;
  assign saveBusy = (state_reg == ST_SAVE_RD) || (state_reg == ST_SAVE_WR);
endmodule
`default_nettype wire

/* File: testbench/sras_host_model.sv */
// Behavioural serial host: mode 3, 16-bit frames, most significant bit first
`default_nettype none
module sras_host_model (
  input wire logic clk,
  input wire logic miso,
  output logic sclk,
  output logic csN,
  output logic mosi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk = 1'b1;
    csN = 1'b1;
    mosi = 1'b0;
  end
  // Eight system cycles per serial bit gives the 200 ns serial period
  task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp);
    csN <= 1'b0;
    repeat (6) @(posedge clk);
    for (int i = 15; i >= 0; i--) begin
      sclk <= 1'b0;
      mosi <= cmd[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      rsp[i] = miso;
      repeat (4) @(posedge clk);
    end
    // Select held past the last edge; released data line toggles
    repeat (14) @(posedge clk);
    csN <= 1'b1;
    mosi <= ~mosi;
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* File: testbench/sras_spi_shadow_assertions.sv */
// Concurrent checks on the serial port pins and status outputs
`default_nettype none
module sras_spi_shadow_assertions (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic sclkPin,
  input wire logic csPin_n,
  input wire logic misoPin,
  input wire logic rstPin_n,
  input wire logic cfgReady,
  input wire logic [15:0] ctrlWord,
  input wire logic saveBusy
);
  default clocking cb @(posedge sys_clk); endclocking
  property p_pinReset;
    disable iff (sys_rst) !rstPin_n [*3] |=> !cfgReady && !saveBusy && ctrlWord == 16'h0000;
  endproperty
  a_pinReset: assert property (p_pinReset) else $error("pin reset left outputs set");
  property p_loadWalk;
    disable iff (sys_rst || !rstPin_n)
      $fell(sys_rst) |-> (!cfgReady throughout ##100 1'b1) ##[1:40] cfgReady;
  endproperty
  a_loadWalk: assert property (p_loadWalk) else $error("ready not after load walk");
  property p_readyHolds;
    disable iff (sys_rst || !rstPin_n) cfgReady |=> cfgReady;
  endproperty
  a_readyHolds: assert property (p_readyHolds) else $error("ready dropped");
  property p_misoOnFall;
    disable iff (sys_rst || !rstPin_n) $changed(misoPin) |-> !$past(sclkPin, 2);
  endproperty
  a_misoOnFall: assert property (p_misoOnFall) else $error("output moved off falling edge");
  property p_misoQuiet;
    disable iff (sys_rst || !rstPin_n) csPin_n [*6] |-> $stable(misoPin);
  endproperty
  a_misoQuiet: assert property (p_misoQuiet) else $error("output moved while deselected");
  property p_ctrlCause;
    disable iff (sys_rst || !rstPin_n)
      $changed(ctrlWord) && cfgReady && $past(cfgReady) |-> !$past(csPin_n, 3);
  endproperty
  a_ctrlCause: assert property (p_ctrlCause) else $error("control word changed unasked");
  property p_saveCause;
    disable iff (sys_rst || !rstPin_n) $rose(saveBusy) |-> !$past(csPin_n, 4);
  endproperty
  a_saveCause: assert property (p_saveCause) else $error("save started without a frame");
  property p_saveLen;
    disable iff (sys_rst || !rstPin_n)
      $rose(saveBusy) |-> (saveBusy throughout ##120 1'b1) ##[1:20] !saveBusy;
  endproperty
  a_saveLen: assert property (p_saveLen) else $error("save walk length wrong");
endmodule
bind sras_spi_shadow sras_spi_shadow_assertions chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .sclkPin(sclkPin), .csPin_n(csPin_n), .misoPin(misoPin), .rstPin_n(rstPin_n),
  .cfgReady(cfgReady), .ctrlWord(ctrlWord), .saveBusy(saveBusy));
`default_nettype wire

/* File: testbench/sras_spi_shadow_test.sv */
// Self-checking bench for the serial register port with backed-up configuration
`default_nettype none
module sras_spi_shadow_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, rstPinN, sclk, csN, mosi, miso, cfgReady, saveBusy;
  logic [15:0] ctrlWord, rsp;
  logic [255:0] outWords;
  logic sampleValid;
  logic [15:0] sampleX, sampleY, sampleZ;
  int num_errors = 0;
  int comparisons = 0;
  sras_spi_shadow dut (.sys_clk(clk), .sys_rst(rst), .sclkPin(sclk), .csPin_n(csN),
    .mosiPin(mosi), .misoPin(miso), .rstPin_n(rstPinN), .outWords(outWords),
    .sampleValid(sampleValid), .sampleX(sampleX), .sampleY(sampleY), .sampleZ(sampleZ),
    .cfgReady(cfgReady), .ctrlWord(ctrlWord), .saveBusy(saveBusy));
  sras_host_model host (.clk(clk), .miso(miso), .sclk(sclk), .csN(csN), .mosi(mosi));
  function automatic logic [15:0] outWord(int k);
    return {4'hC, k[3:0], 4'h5, ~k[3:0]};
  endfunction
  task automatic check16(string name, logic [15:0] exp, logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic rd(logic [5:0] idx, logic up);
    host.xfer({1'b0, idx, up, 8'h00}, rsp);
  endtask
  task automatic wr(logic [5:0] idx, logic up, logic [7:0] d);
    host.xfer({1'b1, idx, up, d}, rsp);
  endtask
  task automatic wait_ready;
    for (int i = 0; i < 300 && cfgReady !== 1'b1; i++) @(posedge clk);
    check16("cfgReady", 16'h0001, {15'h0000, cfgReady});
  endtask
  task automatic pin_reset;
    rstPinN <= 1'b0;
    repeat (4) @(posedge clk);
    rstPinN <= 1'b1;
    @(posedge clk);
    check16("cfgLoading", 16'h0000, {15'h0000, cfgReady});
    wait_ready();
  endtask
  // Chained reads: each frame carries the next command
  task automatic t_read;
    rd(6'h05, 1'b0);
    rd(6'h05, 1'b1);
    check16("rdLower", outWord(5), rsp);
    wr(6'h05, 1'b0, 8'hFF);
    check16("rdUpper", outWord(5), rsp);
    rd(6'h05, 1'b0);
    check16("afterWrite", 16'h0000, rsp);
    rd(6'h3B, 1'b0);
    check16("roKept", outWord(5), rsp);
    rd(6'h00, 1'b0);
    check16("woRead", 16'h0000, rsp);
  endtask
  task automatic t_write;
    wr(6'h10, 1'b0, 8'h34);
    check16("ctrlLow", 16'h0034, ctrlWord);
    wr(6'h10, 1'b1, 8'h12);
    check16("ctrlBoth", 16'h1234, ctrlWord);
    rd(6'h10, 1'b1);
    rd(6'h00, 1'b0);
    check16("ctrlRead", 16'h1234, rsp);
  endtask
  // Unsaved edits are lost on reset; saved ones come back
  task automatic t_save;
    pin_reset();
    check16("noSave", 16'h0000, ctrlWord);
    wr(6'h10, 1'b0, 8'h34);
    wr(6'h10, 1'b1, 8'h12);
    wr(6'h3B, 1'b0, 8'h08);
    check16("saveBusy", 16'h0001, {15'h0000, saveBusy});
    for (int i = 0; i < 300 && saveBusy !== 1'b0; i++) @(posedge clk);
    wr(6'h10, 1'b0, 8'h55);
    check16("ctrlNew", 16'h1255, ctrlWord);
    pin_reset();
    check16("ctrlRestored", 16'h1234, ctrlWord);
  endtask
  task automatic sample(logic [15:0] x, logic [15:0] y, logic [15:0] z);
    sampleX <= x;
    sampleY <= y;
    sampleZ <= z;
    sampleValid <= 1'b1;
    @(posedge clk);
    sampleValid <= 1'b0;
    @(posedge clk);
  endtask
  // A sample offered during the load walk must not reach the buffer
  task automatic t_capture;
    rstPinN <= 1'b0;
    repeat (4) @(posedge clk);
    rstPinN <= 1'b1;
    repeat (20) @(posedge clk);
    sample(16'hAAAA, 16'hBBBB, 16'hCCCC);
    wait_ready();
    sample(16'h1111, 16'h2222, 16'h3333);
    sample(16'h4444, 16'h5555, 16'h6666);
    rd(6'h0B, 1'b0);
    rd(6'h0C, 1'b0);
    check16("captX", 16'h1111, rsp);
    rd(6'h0D, 1'b0);
    check16("captY", 16'h2222, rsp);
    rd(6'h0B, 1'b0);
    check16("captZ", 16'h3333, rsp);
    rd(6'h00, 1'b0);
    check16("captNext", 16'h4444, rsp);
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    rstPinN = 1'b1;
    sampleValid = 1'b0;
    sampleX = 16'h0000;
    sampleY = 16'h0000;
    sampleZ = 16'h0000;
    for (int k = 0; k < 16; k++) outWords[16*k +: 16] = outWord(k);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wait_ready();
    t_read();
    t_write();
    t_save();
    t_capture();
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    finish_test();
  end
endmodule
`default_nettype wire
